//--- rtl/rcs_sequencer.sv
// Purpose: Receiver control line sequencer with AHB-Lite register slave
// Assumes: Single-word transfers, zero wait states, synchronous inputs
// Notes:   Rules of the sequencer follow
// Contract
// - Eight control lines driven from programmed setting patterns.
// - Each setting programs pattern, duration and battery poll.
// - Demod enable turns line zero into the demodulator input.
// - With demod enabled, line zero bit of active setting picks fast or slow slicer tracking.
// - Lines float after reset until forced or decoder turned on.
// - Once on, lines stay driven until next reset, except line zero while demod enabled.
// - Automatic warm-up starts 160ms ahead, up to six steps.
// - Auto warm-up: off time, then enabled steps until first disabled.
// - Auto warm-up ends in sync setting of the current symbol rate.
// - Auto warm-up overrunning 160ms triggers the shut-down sequence.
// - Host warm-up on turn-on, noise detect or sync search request.
// - Host warm-up skips off time; ends in 3200 or 1600 sync.
// - After host warm-up, symbols invalid until 3200 sync time expires.
// - Shut-down: up to three enabled steps, then the Off setting.
// - Disabled first shut-down step goes straight to Off.
// - Turning off while receiver on or warming runs shut-down.
// - Turn-on during shut-down waits for shut-down to finish.
// - Two receive states, sync and data, decode both symbol inputs.
// - After auto warm-up, sync setting follows the symbol rate being searched.
// - Found C sync word selects data setting of the frame rate.
// - Polled setting samples low battery just before leaving it.
// - Differing consecutive battery samples raise a status report.
// - Battery level flag holds last sample, set to inverted LBP bit at turn-on, cleared at reset.
// - Change flag: not set by turn-on, clear on read, reset zero.
`timescale 1ns/10ps
`default_nettype none
module rcs_sequencer #(
    parameter int MS_CYCLES = rcs_pkg::MS_CYCLES
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_nrst,
    input  wire logic             hsel,
    input  wire logic [31:0]      haddr,
    input  wire logic [1:0]       htrans,
    input  wire logic             hwrite,
    input  wire logic [2:0]       hsize,
    input  wire logic [31:0]      hwdata,
    input  wire logic             hready,
    output logic [31:0]           hrdata,
    output logic                  hreadyout,
    output logic                  hresp,
    input  wire rcs_pkg::rcs_dec_s i_dec,
    input  wire logic             i_line0,
    input  wire logic             i_low_battery,
    input  wire logic             i_symbol_0,
    input  wire logic             i_symbol_1,
    output logic [7:0]            o_ctrl_line,
    output logic [7:0]            o_ctrl_oe,
    output logic                  o_demod_in,
    output logic                  o_slicer_fast,
    output logic                  o_decode_en,
    output logic                  o_symbols_valid,
    output logic [1:0]            o_symbols,
    output logic                  o_status_report
);
    rcs_pkg::rcs_setting_s set_r [rcs_pkg::NUM_SET];
    rcs_pkg::rcs_state_e   st_r, st_nxt;
    rcs_pkg::rcs_idx_e     idx_r, idx_nxt;
    logic [31:0]           ctrl_r;
    logic [7:0]            force_r;
    logic                  on_seen_r, on_d_r, host_r, host_nxt;
    logic                  pend_r, pend_search_r, start_host;
    logic [7:0]            step_cnt_r, val_cnt_r;
    logic                  load_step, load_win, load_val;
    logic [$clog2(MS_CYCLES)-1:0] div_r;
    logic                  tick;
    logic                  batt_lvl_r, batt_seen_r, chg_r, sample;
    logic                  ph_wr_r, ph_rd_r;
    logic [7:0]            ph_addr_r;
    logic                  on, demod_en, on_rise, rd_status;

    function automatic rcs_pkg::rcs_idx_e idx_plus(input rcs_pkg::rcs_idx_e i);
        idx_plus = rcs_pkg::rcs_idx_e'(i + 4'h1);
    endfunction

    assign on      = ctrl_r[rcs_pkg::CTRL_ON];
    assign demod_en = ctrl_r[rcs_pkg::CTRL_DEMOD];
    assign on_rise = on & ~on_d_r;

    // AHB-Lite slave: zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            ph_wr_r   <= 1'b0;
            ph_rd_r   <= 1'b0;
            ph_addr_r <= 8'h00;
        end
        else if (hready)
        begin
            ph_wr_r   <= hsel & htrans[1] & hwrite;
            ph_rd_r   <= hsel & htrans[1] & ~hwrite;
            ph_addr_r <= haddr[7:0];
        end
    end

    assign rd_status = ph_rd_r && (ph_addr_r == rcs_pkg::ADDR_STATUS);

    always_comb
    begin
        hrdata = 32'h0000_0000;
        if (ph_addr_r == rcs_pkg::ADDR_CTRL)
            hrdata = {29'h0, ctrl_r[2:0]};
        else if (ph_addr_r == rcs_pkg::ADDR_FORCE)
            hrdata = {24'h0, force_r};
        else if (ph_addr_r == rcs_pkg::ADDR_STATUS)
            hrdata = {16'h0, 4'(idx_r), 1'b0, 3'(st_r), 4'h0,
                      o_symbols_valid, chg_r, batt_lvl_r, on_seen_r};
        else if (ph_addr_r >= rcs_pkg::ADDR_SET0 &&
                 ph_addr_r < rcs_pkg::ADDR_SET0 + 8'(4 * rcs_pkg::NUM_SET))
            hrdata = {8'h0, set_r[4'(ph_addr_r[5:2])].dur, 6'h0,
                      set_r[4'(ph_addr_r[5:2])].en, set_r[4'(ph_addr_r[5:2])].poll,
                      set_r[4'(ph_addr_r[5:2])].pat};
    end

    // Control register; request bits are one-shot
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            ctrl_r <= rcs_pkg::CTRL_RST;
            force_r <= 8'h00;
        end
        else
        begin
            ctrl_r[rcs_pkg::CTRL_NOISE]  <= 1'b0;
            ctrl_r[rcs_pkg::CTRL_SEARCH] <= 1'b0;
            if (ph_wr_r && ph_addr_r == rcs_pkg::ADDR_CTRL)
                ctrl_r <= {27'h0, hwdata[4:0]};
            if (ph_wr_r && ph_addr_r == rcs_pkg::ADDR_FORCE)
                force_r <= hwdata[7:0];
        end
    end

    // Setting table
    for (genvar g = 0; g < rcs_pkg::NUM_SET; g++)
    begin : g_set
        always_ff @(posedge i_core_clk)
        begin
            if (!i_nrst)
                set_r[g] <= rcs_pkg::SET_RST;
            else if (ph_wr_r && ph_addr_r == rcs_pkg::ADDR_SET0 + 8'(4 * g))
                set_r[g] <= {hwdata[23:16], hwdata[9], hwdata[8], hwdata[7:0]};
        end
    end

    // Millisecond tick divider
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst || tick)
            div_r <= '0;
        else
            div_r <= div_r + 1'b1;
    end
    assign tick = (div_r == ($clog2(MS_CYCLES))'(MS_CYCLES - 1));

    // Host requests latch until a warm-up can start
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            pend_r     <= 1'b0;
            pend_search_r <= 1'b0;
            on_d_r     <= 1'b0;
        end
        else
        begin
            on_d_r <= on;
            if (start_host)
                pend_r <= 1'b0;
            if (on_rise || ctrl_r[rcs_pkg::CTRL_NOISE] || ctrl_r[rcs_pkg::CTRL_SEARCH])
            begin
                pend_r        <= 1'b1;
                pend_search_r <= ctrl_r[rcs_pkg::CTRL_SEARCH] & ~on_rise;
            end
        end
    end

    // Sequencer next state
    always_comb
    begin
        st_nxt     = st_r;
        idx_nxt    = idx_r;
        host_nxt   = host_r;
        load_step  = 1'b0;
        load_win   = 1'b0;
        load_val   = 1'b0;
        start_host = 1'b0;
        case (st_r)
            rcs_pkg::ST_IDLE:
            begin
                if (on && pend_r)
                begin
                    start_host = 1'b1;
                    host_nxt   = 1'b1;
                    st_nxt     = rcs_pkg::ST_WARM;
                    idx_nxt    = rcs_pkg::SI_WU1;
                    load_step  = 1'b1;
                end
                else if (on && i_dec.auto_wake)
                begin
                    host_nxt  = 1'b0;
                    st_nxt    = rcs_pkg::ST_WOFF;
                    idx_nxt   = rcs_pkg::SI_OFF;
                    load_step = 1'b1;
                    load_win  = 1'b1;
                end
            end
            rcs_pkg::ST_WOFF, rcs_pkg::ST_WARM:
            begin
                if (!on || (!host_r && val_cnt_r == 8'h00))
                    st_nxt = rcs_pkg::ST_SHUT;
                else if (step_cnt_r == 8'h00)
                begin
                    st_nxt    = rcs_pkg::ST_WARM;
                    idx_nxt   = (st_r == rcs_pkg::ST_WOFF) ? rcs_pkg::SI_WU1 : idx_plus(idx_r);
                    load_step = 1'b1;
                end
            end
            rcs_pkg::ST_SYNC:
            begin
                if (!on || i_dec.rx_off)
                    st_nxt = rcs_pkg::ST_SHUT;
                else if (i_dec.csync_found)
                begin
                    st_nxt  = rcs_pkg::ST_DATA;
                    idx_nxt = i_dec.rate_3200 ? rcs_pkg::SI_DA32 : rcs_pkg::SI_DA16;
                end
                else if (!host_r)
                    idx_nxt = i_dec.rate_3200 ? rcs_pkg::SI_SY32 : rcs_pkg::SI_SY16;
            end
            rcs_pkg::ST_DATA:
            begin
                if (!on || i_dec.rx_off)
                    st_nxt = rcs_pkg::ST_SHUT;
            end
            rcs_pkg::ST_SHUT:
            begin
                if (step_cnt_r == 8'h00)
                begin
                    idx_nxt   = idx_plus(idx_r);
                    load_step = 1'b1;
                    if (idx_r == rcs_pkg::SI_SD3 || !set_r[idx_plus(idx_r)].en)
                    begin
                        st_nxt  = rcs_pkg::ST_IDLE;
                        idx_nxt = rcs_pkg::SI_OFF;
                    end
                end
            end
            default:
            begin
                st_nxt  = rcs_pkg::ST_IDLE;
                idx_nxt = rcs_pkg::SI_OFF;
            end
        endcase
        // Leaving warm-up past the last enabled step lands on a sync setting
        if (st_nxt == rcs_pkg::ST_WARM &&
            (idx_nxt > rcs_pkg::SI_WU6 || idx_nxt == rcs_pkg::SI_OFF || !set_r[idx_nxt].en))
        begin
            st_nxt = rcs_pkg::ST_SYNC;
            if (host_nxt)
            begin
                idx_nxt  = pend_search_r ? rcs_pkg::SI_SY16 : rcs_pkg::SI_SY32;
                load_val = 1'b1;
            end
            else
                idx_nxt = i_dec.rate_3200 ? rcs_pkg::SI_SY32 : rcs_pkg::SI_SY16;
        end
        // Entering shut-down picks the first step or Off
        if (st_nxt == rcs_pkg::ST_SHUT && st_r != rcs_pkg::ST_SHUT)
        begin
            load_step = 1'b1;
            if (set_r[rcs_pkg::SI_SD1].en)
                idx_nxt = rcs_pkg::SI_SD1;
            else
            begin
                st_nxt  = rcs_pkg::ST_IDLE;
                idx_nxt = rcs_pkg::SI_OFF;
            end
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            st_r   <= rcs_pkg::ST_IDLE;
            idx_r  <= rcs_pkg::SI_OFF;
            host_r <= 1'b0;
        end
        else
        begin
            st_r   <= st_nxt;
            idx_r  <= idx_nxt;
            host_r <= host_nxt;
        end
    end

    // Step timer and warm-up window / valid-signal timer
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
            step_cnt_r <= 8'h00;
        else if (load_step)
            step_cnt_r <= set_r[idx_nxt].dur;
        else if (tick && step_cnt_r != 8'h00)
            step_cnt_r <= step_cnt_r - 8'h01;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
            val_cnt_r <= 8'h00;
        else if (load_win)
            val_cnt_r <= rcs_pkg::WARM_WIN_MS;
        else if (load_val)
            val_cnt_r <= set_r[rcs_pkg::SI_SY32].dur;
        else if (tick && val_cnt_r != 8'h00)
            val_cnt_r <= val_cnt_r - 8'h01;
    end

    // Line drive
    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            on_seen_r   <= 1'b0;
            o_ctrl_line <= 8'h00;
        end
        else
        begin
            if (on)
                on_seen_r <= 1'b1;
            o_ctrl_line <= set_r[idx_nxt].pat;
        end
    end

    always_comb
    begin
        o_ctrl_oe    = force_r | {8{on_seen_r}};
        o_ctrl_oe[0] = o_ctrl_oe[0] & ~demod_en;
    end
    assign o_demod_in      = demod_en & i_line0;
    assign o_slicer_fast   = demod_en & set_r[idx_r].pat[0];
    assign o_decode_en     = (st_r == rcs_pkg::ST_SYNC) || (st_r == rcs_pkg::ST_DATA);
    assign o_symbols_valid = o_decode_en && (val_cnt_r == 8'h00);
    assign o_symbols       = o_decode_en ? {i_symbol_1, i_symbol_0} : 2'b00;

    // Battery polling
    assign sample = (idx_nxt != idx_r) && set_r[idx_r].poll;

    always_ff @(posedge i_core_clk)
    begin
        if (!i_nrst)
        begin
            batt_lvl_r      <= 1'b0;
            batt_seen_r     <= 1'b0;
            chg_r           <= 1'b0;
            o_status_report <= 1'b0;
        end
        else
        begin
            o_status_report <= 1'b0;
            if (rd_status)
                chg_r <= 1'b0;
            if (on_rise)
            begin
                batt_lvl_r  <= ~ctrl_r[rcs_pkg::CTRL_LBP];
                batt_seen_r <= 1'b0;
            end
            else if (sample)
            begin
                batt_lvl_r  <= i_low_battery;
                batt_seen_r <= 1'b1;
                if (batt_seen_r && i_low_battery != batt_lvl_r)
                begin
                    chg_r           <= 1'b1;
                    o_status_report <= 1'b1;
                end
            end
        end
    end

    property p_float;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (!on_seen_r && force_r == 8'h00) |-> (o_ctrl_oe == 8'h00);
    endproperty
    a_float: assert property (p_float) else $error("lines driven too early");

    property p_stay_on;
        @(posedge i_core_clk) disable iff (!i_nrst)
        on_seen_r |=> (o_ctrl_oe == {7'h7f, ~demod_en}) [*4];
    endproperty
    a_stay_on: assert property (p_stay_on) else $error("lines released");

    property p_pattern;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (idx_r == $past(idx_r) && !$past(ph_wr_r)) |-> (o_ctrl_line == set_r[idx_r].pat);
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern mismatch");

    property p_demod;
        @(posedge i_core_clk) disable iff (!i_nrst)
        demod_en |-> (!o_ctrl_oe[0] && o_demod_in == i_line0);
    endproperty
    a_demod: assert property (p_demod) else $error("line zero driven");

    property p_slicer;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (demod_en && o_decode_en && !$past(ph_wr_r)) |->
            (o_slicer_fast == o_ctrl_line[0]) or (idx_r != $past(idx_r));
    endproperty
    a_slicer: assert property (p_slicer) else $error("slicer mode wrong");

    property p_off_direct;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (o_decode_en && !on && !set_r[rcs_pkg::SI_SD1].en) |=>
            (st_r == rcs_pkg::ST_IDLE && idx_r == rcs_pkg::SI_OFF);
    endproperty
    a_off_direct: assert property (p_off_direct) else $error("no direct off");

    property p_turnon_lb;
        @(posedge i_core_clk) disable iff (!i_nrst)
        on_rise |=> (batt_lvl_r == ~$past(ctrl_r[rcs_pkg::CTRL_LBP]) && !o_status_report);
    endproperty
    a_turnon_lb: assert property (p_turnon_lb) else $error("turn-on level wrong");

    property p_change;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (sample && !on_rise && batt_seen_r && i_low_battery != batt_lvl_r && !rd_status)
            |=> (chg_r && o_status_report) ##1 !o_status_report;
    endproperty
    a_change: assert property (p_change) else $error("change not reported");

    property p_host_valid;
        @(posedge i_core_clk) disable iff (!i_nrst)
        (load_val && set_r[rcs_pkg::SI_SY32].dur != 8'h00) |=> !o_symbols_valid;
    endproperty
    a_host_valid: assert property (p_host_valid) else $error("valid too early");
endmodule
`default_nettype wire

//--- rtl/rcs_pkg.sv
// Purpose: Shared constants and types for the receiver control sequencer
// Assumes: 20 MHz core clock, full-word AHB-Lite accesses
// Notes:   Setting words hold pattern, poll, enable and a duration in ms
package rcs_pkg;
    localparam int          CLK_NS       = 50;
    localparam int          MS_NS        = 1000000;
    localparam int          MS_CYCLES    = MS_NS / CLK_NS;
    localparam logic [7:0]  WARM_WIN_MS  = 8'ha0;
    localparam int          NUM_LINES    = 8;
    localparam int          NUM_SET      = 14;
    // Register byte addresses
    localparam logic [7:0]  ADDR_CTRL    = 8'h00;
    localparam logic [7:0]  ADDR_FORCE   = 8'h04;
    localparam logic [7:0]  ADDR_STATUS  = 8'h08;
    localparam logic [7:0]  ADDR_SET0    = 8'h40;
    // Control bits
    localparam int          CTRL_ON      = 0;
    localparam int          CTRL_DEMOD   = 1;
    localparam int          CTRL_LBP     = 2;
    localparam int          CTRL_NOISE   = 3;
    localparam int          CTRL_SEARCH  = 4;
    // Setting word fields
    localparam int          SET_POLL     = 8;
    localparam int          SET_EN       = 9;
    localparam int          SET_DUR_LSB  = 16;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
    localparam logic [17:0] SET_RST      = 18'h0_0000;

    typedef enum logic [3:0] {
        SI_OFF  = 4'h0, SI_WU1  = 4'h1, SI_WU2  = 4'h2, SI_WU3  = 4'h3,
        SI_WU4  = 4'h4, SI_WU5  = 4'h5, SI_WU6  = 4'h6, SI_SD1  = 4'h7,
        SI_SD2  = 4'h8, SI_SD3  = 4'h9, SI_SY16 = 4'ha, SI_SY32 = 4'hb,
        SI_DA16 = 4'hc, SI_DA32 = 4'hd
    } rcs_idx_e;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_WOFF = 3'h1, ST_WARM = 3'h2,
        ST_SYNC = 3'h3, ST_DATA = 3'h4, ST_SHUT = 3'h5
    } rcs_state_e;

    typedef struct packed {
        logic [7:0] dur;
        logic       en;
        logic       poll;
        logic [7:0] pat;
    } rcs_setting_s;

    typedef struct packed {
        logic       auto_wake;
        logic       rate_3200;
        logic       csync_found;
        logic       rx_off;
    } rcs_dec_s;
endpackage

//--- dv/rcs_rx_model.sv
// Purpose: Behavioural paging receiver at the far side of the control lines
// Assumes: Control lines have pull-downs; receiver is on for any nonzero pattern
// Notes:   Released line zero carries the receiver's own demodulated data
`timescale 1ns/10ps
`default_nettype none
module rcs_rx_model (
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_line,
    input  wire logic [7:0] i_oe,
    input  wire logic       i_batt_pin,
    output logic            o_line0,
    output logic            o_low_battery,
    output logic [1:0]      o_symbols
);
    logic [7:0] pin;
    logic [1:0] cnt = 2'h0;
    // Undriven lines fall to the pull-down level
    assign pin = i_line & i_oe;
    assign o_line0 = i_oe[0] ? i_line[0] : cnt[0];
    assign o_low_battery = i_batt_pin;
    always @(posedge i_core_clk)
        cnt <= cnt + 2'h1;
    // Symbols change every cycle, inverted while the receiver is off
    assign o_symbols = (|pin) ? cnt : ~cnt;
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Purpose: Directed bench for the receiver control sequencer
// Assumes: One ms is shortened to four core cycles
// Notes:   Sequencing is followed through the control line patterns
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int MSC = 4;
    logic             clk = 1'b0;
    logic             i_nrst = 1'b0;
    logic [31:0]      haddr = 32'h0;
    logic [1:0]       htrans = 2'h0;
    logic             hwrite = 1'b0;
    logic [31:0]      hwdata = 32'h0;
    logic [31:0]      hrdata;
    logic             hreadyout;
    logic             hresp;
    rcs_pkg::rcs_dec_s dec = '0;
    logic             line0;
    logic             batt_pin = 1'b0;
    logic             low_bat;
    logic [1:0]       sym;
    logic [7:0]       line;
    logic [7:0]       oe;
    logic             demod;
    logic             fast;
    logic             dec_en;
    logic             valid;
    logic [1:0]       syms;
    logic             rep;
    logic             rep_seen = 1'b0;
    logic [31:0]      rdv;
    int               errors = 0;
    int               samples_checked = 0;
    int               n;
    logic [31:0]      tbl [14] = '{32'h0002_0000, 32'h0002_0212, 32'h0001_0224,
        32'h0, 32'h0, 32'h0, 32'h0, 32'h0003_0333, 32'h0, 32'h0,
        32'h0002_0041, 32'h0003_0081, 32'h0000_0050, 32'h0000_0060};

    rcs_sequencer #(.MS_CYCLES(MSC)) u_dut (
        .i_core_clk(clk), .i_nrst(i_nrst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .i_dec(dec), .i_line0(line0), .i_low_battery(low_bat),
        .i_symbol_0(sym[0]), .i_symbol_1(sym[1]), .o_ctrl_line(line),
        .o_ctrl_oe(oe), .o_demod_in(demod), .o_slicer_fast(fast),
        .o_decode_en(dec_en), .o_symbols_valid(valid), .o_symbols(syms),
        .o_status_report(rep));
    rcs_rx_model u_rx (
        .i_core_clk(clk), .i_line(line), .i_oe(oe), .i_batt_pin(batt_pin),
        .o_line0(line0), .o_low_battery(low_bat), .o_symbols(sym));

    initial
    begin
        forever #25 clk = ~clk;
    end
    always @(posedge clk)
        if (rep === 1'b1)
            rep_seen <= 1'b1;

    task final_report;
        if (errors == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e)
        begin
            $display("Error %0t: got %h expected %h", $time, g, e);
            errors++;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        logic r;
        @(posedge clk);
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {24'h0, a};
        do
        begin
            @(negedge clk);
            r = hreadyout;
            @(posedge clk);
        end
        while (r !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do
        begin
            @(negedge clk);
            r = hreadyout;
            rdv = hrdata;
            @(posedge clk);
        end
        while (r !== 1'b1);
    endtask
    task ev(input logic [3:0] m);
        @(posedge clk);
        dec <= rcs_pkg::rcs_dec_s'(dec | m);
        @(posedge clk);
        dec <= rcs_pkg::rcs_dec_s'(dec & ~m);
    endtask
    task wait_line(input logic [7:0] v);
        int k;
        k = 0;
        @(negedge clk);
        while (line !== v && k < 2000)
        begin
            @(negedge clk);
            k++;
        end
        chk({24'h0, line}, {24'h0, v});
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        errors++;
        final_report;
    end
    initial
    begin
        repeat (6) @(posedge clk);
        i_nrst <= 1'b1;
        bus(0, rcs_pkg::ADDR_CTRL, 0);
        chk(rdv, rcs_pkg::CTRL_RST);
        chk({31'h0, hresp}, 32'h0);
        bus(0, rcs_pkg::ADDR_STATUS, 0);
        chk(rdv, 32'h0);
        bus(0, rcs_pkg::ADDR_SET0, 0);
        chk(rdv, 32'h0);
        chk({24'h0, oe}, 32'h0);
        bus(1, 8'h30, 32'hffff_ffff);
        bus(0, 8'h30, 0);
        chk(rdv, 32'h0);
        bus(1, rcs_pkg::ADDR_FORCE, 32'h0f);
        @(negedge clk);
        chk({24'h0, oe}, 32'h0f);
        for (int i = 0; i < 14; i++)
            bus(1, rcs_pkg::ADDR_SET0 + 8'(4 * i), tbl[i]);
        bus(0, rcs_pkg::ADDR_SET0 + 8'h04, 0);
        chk(rdv, tbl[1]);
        batt_pin <= 1'b1;
        bus(1, rcs_pkg::ADDR_CTRL, 32'h7);
        wait_line(8'h12);
        chk({24'h0, oe}, 32'hfe);
        chk({31'h0, fast}, 32'h0);
        wait_line(8'h24);
        wait_line(8'h81);
        chk({30'h0, fast, dec_en}, 32'h3);
        chk({31'h0, demod}, {31'h0, line0});
        chk({31'h0, valid}, 32'h0);
        chk({30'h0, syms}, {30'h0, sym});
        n = 0;
        while (valid !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n++;
        end
        chk({31'h0, n > 5 && n < 100}, 32'h1);
        @(posedge clk);
        dec.rate_3200 <= 1'b1;
        ev(4'h2);
        wait_line(8'h60);
        ev(4'h1);
        wait_line(8'h33);
        wait_line(8'h00);
        chk({24'h0, oe}, 32'hfe);
        bus(0, rcs_pkg::ADDR_STATUS, 0);
        chk(rdv & 32'h6, 32'h2);
        chk({31'h0, rep_seen}, 32'h0);
        batt_pin <= 1'b0;
        dec.rate_3200 <= 1'b0;
        ev(4'h8);
        bus(0, rcs_pkg::ADDR_STATUS, 0);
        chk(rdv & 32'h700, 32'h100);
        wait_line(8'h12);
        wait_line(8'h24);
        wait_line(8'h41);
        ev(4'h1);
        wait_line(8'h33);
        wait_line(8'h00);
        @(negedge clk);
        chk({31'h0, rep_seen}, 32'h1);
        bus(0, rcs_pkg::ADDR_STATUS, 0);
        chk(rdv & 32'h6, 32'h4);
        bus(0, rcs_pkg::ADDR_STATUS, 0);
        chk(rdv & 32'h4, 32'h0);
        bus(1, rcs_pkg::ADDR_CTRL, 32'h17);
        wait_line(8'h12);
        wait_line(8'h41);
        bus(1, rcs_pkg::ADDR_CTRL, 32'h6);
        wait_line(8'h33);
        bus(1, rcs_pkg::ADDR_CTRL, 32'h7);
        wait_line(8'h00);
        wait_line(8'h12);
        wait_line(8'h81);
        ev(4'h1);
        wait_line(8'h00);
        bus(1, rcs_pkg::ADDR_SET0 + 8'h08, 32'h00c8_0224);
        ev(4'h8);
        wait_line(8'h24);
        wait_line(8'h33);
        wait_line(8'h00);
        // Disable the first shut-down step, then noise-detect warm-up with demod off
        bus(1, rcs_pkg::ADDR_SET0 + 8'h1c, 32'h0003_0133);
        bus(1, rcs_pkg::ADDR_CTRL, 32'h0d);
        wait_line(8'h24);
        wait_line(8'h81);
        bus(1, rcs_pkg::ADDR_CTRL, 32'h4);
        repeat (2) @(negedge clk);
        chk({24'h0, line}, 32'h0);
        chk({24'h0, oe}, 32'hff);
        chk({30'h0, fast, demod}, 32'h0);
        final_report;
    end
endmodule
`default_nettype wire
